// ==== rtl/gpfs_regs.vh ====
// Register offsets, field positions, reset values and function codes of the low-bank pin selector.
`ifndef GPFS_REGS_VH
`define GPFS_REGS_VH
// ==========================================
// Register offsets
`define GPFS_ADDR_POL       8'h87
`define GPFS_ADDR_FSEL      8'h8c
`define GPFS_ADDR_STAT      8'h8e
// ==========================================
// Reset values and writable masks
`define GPFS_POL_RST        16'h0000
`define GPFS_POL_MASK       16'h01ff
`define GPFS_FSEL_RST       16'h0013
// ==========================================
// Field positions of the function-select register and the pin 0 polarity bit
`define GPFS_FLD_W          4
`define GPFS_FLD_P0_LSB     0
`define GPFS_FLD_P1_LSB     4
`define GPFS_FLD_P2_LSB     8
`define GPFS_FLD_P3_LSB     12
`define GPFS_POL_P0_BIT     0
// ==========================================
// Function codes and highest listed code per table
`define GPFS_FN_GPIO        4'h0
`define GPFS_FN_C1          4'h1
`define GPFS_FN_C2          4'h2
`define GPFS_FN_C3          4'h3
`define GPFS_FN_C4          4'h4
`define GPFS_FN_C5          4'h5
`define GPFS_IN_MAX_ALL     16'h4445
`define GPFS_OUT_MAX_ALL    16'h4444
`endif

// ==== rtl/gpfs_sel_dec.v ====
// Function-field decoder that maps a code to a listed function or to plain GPIO.
`timescale 1ns/1ps
`include "gpfs_regs.vh"
module gpfs_sel_dec #(
  parameter NF = 6
) (
  input  wire [3:0]    code,     // Raw function field.
  input  wire [3:0]    max_code, // Highest code that the table lists.
  input  wire          en,       // Table in use for this pin direction.
  output wire [3:0]    cln_code, // Listed code, or GPIO when unlisted or unused.
  output wire [NF-1:0] hot       // One-hot of the clean code.
);
  // ==========================================
  // Decode
  // Codes above the table fall back to plain GPIO.
  assign cln_code = (en && (code <= max_code)) ? code : `GPFS_FN_GPIO;
  genvar i;
  generate
    for (i = 0; i < NF; i = i + 1) begin : g_hot
      // The index is held at field width so the compare is four bits on both sides.
      localparam [3:0] IDX = i;
      assign hot[i] = (cln_code == IDX);
    end
  endgenerate
endmodule // gpfs_sel_dec

// ==== rtl/gpfs_pin_pad.v ====
// Per-pin polarity and drive-type stage for one general-purpose pin.
`timescale 1ns/1ps
module gpfs_pin_pad (
  input  wire core_clk,   // Core clock.
  input  wire rst_n,      // Asynchronous reset, active low.
  input  wire pol_type,   // Polarity in input mode, drive type in output mode.
  input  wire dir_out,    // High when the pin is an output.
  input  wire drive_val,  // Logic level to present when driving.
  input  wire pin_in,     // Level seen on the pin.
  output reg  asserted_r, // Pin input normalised to active high.
  output reg  pin_out_r,  // Pin output value.
  output reg  pin_oe_n_r  // Pin output enable, low while driving.
);
  // ==========================================
  // Registered pin stage
  // Open drain only ever pulls low; push-pull drives both levels.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      asserted_r <= 1'b0;
      pin_out_r  <= 1'b0;
      pin_oe_n_r <= 1'b1;
    end else begin
      asserted_r <= pol_type ? pin_in : ~pin_in;
      if (!dir_out) begin
        pin_out_r  <= 1'b0;
        pin_oe_n_r <= 1'b1;
      end else if (pol_type) begin
        pin_out_r  <= 1'b0;
        pin_oe_n_r <= drive_val;
      end else begin
        pin_out_r  <= drive_val;
        pin_oe_n_r <= 1'b0;
      end
    end
  end
endmodule // gpfs_pin_pad

// ==== rtl/gpfs_top.v ====
// Pin polarity and alternate-function selection for general-purpose pins 0 to 3.
//
// Behaviour
// - Pin 0 polarity bit: input 0 low-active, 1 high; output 0 push-pull, 1 open-drain.
// - Polarity bits live at 87h and return to defaults on sequencer reset; pin 0 is 0.
// - Function select at 8Ch holds four 4-bit fields, restored on sequencer reset.
// - Pin 3 field is bits 15:12, default 0000, with its input and output tables.
// - Pin 2 field is bits 11:8, default 0000, with its input and output tables.
// - Pin 1 field is bits 7:4, default 0001, with its input and output tables.
// - Pin 0 field is bits 3:0, default 0011, with its input and output tables.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "gpfs_regs.vh"
module gpfs_top #(
  parameter NPIN = 4,
  parameter AW   = 8,
  parameter DW   = 16
) (
  input  wire            core_clk,             // Core clock, 100 MHz.
  input  wire            rst_n,                // Asynchronous reset, active low.
  input  wire            sm_reset,             // Sequencer reset pulse, restores defaults.
  input  wire [AW-1:0]   addr,                 // Register address.
  input  wire [DW-1:0]   wr_data,              // Register write data.
  input  wire            wr_en,                // Write strobe.
  input  wire            rd_en,                // Read strobe.
  output reg  [DW-1:0]   rd_data_r,            // Read data, one cycle after the strobe.
  input  wire [NPIN-1:0] gpio_dir_out,         // Pin direction, high for output.
  input  wire [NPIN-1:0] gpio_out_data,        // Plain GPIO output data.
  output wire [NPIN-1:0] gpio_in_data,         // Plain GPIO input data, normalised.
  input  wire [NPIN-1:0] pin_in,               // Pin input levels.
  output wire [NPIN-1:0] pin_out,              // Pin output values.
  output wire [NPIN-1:0] pin_oe_n,             // Pin output enables, low while driving.
  output reg             power_up_request,     // Power-on request from a pin.
  output reg             power_down_request,   // Power-off request from a pin.
  output reg             regulator_enable_in,  // Regulator enable, active high input.
  output reg             regulator_enable_in_n,// Regulator enable, active low input.
  output reg             wake_request_n,       // Wake-up request, active low.
  output reg             low_power_request_1,  // Low-power request 1.
  output reg             low_power_request_2,  // Low-power request 2.
  output reg             low_power_request_3,  // Low-power request 3.
  output reg             flash_trigger,        // Flash trigger request.
  output reg             chip_reset_request,   // Chip reset request.
  output reg             clk_32k_in,           // 32 kHz clock taken from a pin.
  input  wire            clk_1m_src,           // 1 MHz clock to route out.
  input  wire            clk_32k_src,          // 32 kHz clock to route out.
  input  wire            backup_rail_monitor,  // Backup-rail monitor level.
  input  wire            memory_reset_n,       // Memory reset, active low.
  input  wire            sys_reset_n,          // System reset, active low.
  input  wire            por_n,                // Power-on reset, active low.
  input  wire            power_up_state,       // Power-on state to route out.
  input  wire            data_output_config    // Data-output configuration level.
);
  // ==========================================
  // Register state
  reg  [DW-1:0] pol_r;
  reg  [DW-1:0] fsel_r;
  reg  [DW-1:0] rd_nxt;
  wire [NPIN-1:0] asserted;
  wire [NPIN*4-1:0] out_code;
  wire [NPIN*6-1:0] in_hot;
  reg  [NPIN-1:0] drive_val;
  wire [15:0] in_max  = `GPFS_IN_MAX_ALL;
  wire [15:0] out_max = `GPFS_OUT_MAX_ALL;

  // ==========================================
  // Register writes
  // A sequencer reset wins over a write in the same cycle.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pol_r  <= `GPFS_POL_RST;
      fsel_r <= `GPFS_FSEL_RST;
    end else if (sm_reset) begin
      pol_r  <= `GPFS_POL_RST;
      fsel_r <= `GPFS_FSEL_RST;
    end else if (wr_en) begin
      if (addr == `GPFS_ADDR_POL) begin
        pol_r <= wr_data & `GPFS_POL_MASK;
      end
      if (addr == `GPFS_ADDR_FSEL) begin
        fsel_r <= wr_data;
      end
    end
  end

  // ==========================================
  // Register reads
  // Unmapped addresses read as zero; data stands one cycle only.
  always @* begin
    rd_nxt = {DW{1'b0}};
    case (addr)
      `GPFS_ADDR_POL: begin
        rd_nxt = pol_r;
      end
      `GPFS_ADDR_FSEL: begin
        rd_nxt = fsel_r;
      end
      `GPFS_ADDR_STAT: begin
        rd_nxt = {8'h00, gpio_dir_out, asserted};
      end
      default: begin
        rd_nxt = {DW{1'b0}};
      end
    endcase
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r <= {DW{1'b0}};
    end else begin
      rd_data_r <= rd_en ? rd_nxt : {DW{1'b0}};
    end
  end

  // ==========================================
  // Per-pin decoders and pad stages
  // Each field is read through the table that its direction selects.
  genvar p;
  generate
    for (p = 0; p < NPIN; p = p + 1) begin : g_pin
      gpfs_sel_dec #(.NF(6)) u_in_dec (
        .code     (fsel_r[4*p +: 4]),
        .max_code (in_max[4*p +: 4]),
        .en       (~gpio_dir_out[p]),
        .cln_code (),
        .hot      (in_hot[6*p +: 6])
      );
      gpfs_sel_dec #(.NF(6)) u_out_dec (
        .code     (fsel_r[4*p +: 4]),
        .max_code (out_max[4*p +: 4]),
        .en       (gpio_dir_out[p]),
        .cln_code (out_code[4*p +: 4]),
        .hot      ()
      );
      gpfs_pin_pad u_pad (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .pol_type   (pol_r[p]),
        .dir_out    (gpio_dir_out[p]),
        .drive_val  (drive_val[p]),
        .pin_in     (pin_in[p]),
        .asserted_r (asserted[p]),
        .pin_out_r  (pin_out[p]),
        .pin_oe_n_r (pin_oe_n[p])
      );
    end
  endgenerate

  assign gpio_in_data = asserted;

  // ==========================================
  // Output routing
  // Each pin picks its source from its own output table.
  always @* begin
    drive_val = gpio_out_data;
    case (out_code[`GPFS_FLD_P0_LSB +: 4])
      `GPFS_FN_C1: drive_val[0] = power_up_state;
      `GPFS_FN_C2: drive_val[0] = backup_rail_monitor;
      `GPFS_FN_C3: drive_val[0] = por_n;
      `GPFS_FN_C4: drive_val[0] = sys_reset_n;
      default:     drive_val[0] = gpio_out_data[0];
    endcase
    case (out_code[`GPFS_FLD_P1_LSB +: 4])
      `GPFS_FN_C1: drive_val[1] = data_output_config;
      `GPFS_FN_C2: drive_val[1] = sys_reset_n;
      `GPFS_FN_C3: drive_val[1] = memory_reset_n;
      `GPFS_FN_C4: drive_val[1] = clk_32k_src;
      default:     drive_val[1] = gpio_out_data[1];
    endcase
    case (out_code[`GPFS_FLD_P2_LSB +: 4])
      `GPFS_FN_C1: drive_val[2] = power_up_state;
      `GPFS_FN_C2: drive_val[2] = backup_rail_monitor;
      `GPFS_FN_C3: drive_val[2] = clk_32k_src;
      `GPFS_FN_C4: drive_val[2] = sys_reset_n;
      default:     drive_val[2] = gpio_out_data[2];
    endcase
    case (out_code[`GPFS_FLD_P3_LSB +: 4])
      `GPFS_FN_C1: drive_val[3] = clk_1m_src;
      `GPFS_FN_C2: drive_val[3] = backup_rail_monitor;
      `GPFS_FN_C3: drive_val[3] = clk_32k_src;
      `GPFS_FN_C4: drive_val[3] = memory_reset_n;
      default:     drive_val[3] = gpio_out_data[3];
    endcase
  end

  // ==========================================
  // Input routing
  // A function is asserted when any pin selecting it sees its active level.
  wire [NPIN-1:0] sel_c1;
  wire [NPIN-1:0] sel_c2;
  wire [NPIN-1:0] sel_c3;
  wire [NPIN-1:0] sel_c4;
  wire [NPIN-1:0] sel_c5;
  generate
    for (p = 0; p < NPIN; p = p + 1) begin : g_sel
      assign sel_c1[p] = in_hot[6*p+1] & asserted[p];
      assign sel_c2[p] = in_hot[6*p+2] & asserted[p];
      assign sel_c3[p] = in_hot[6*p+3] & asserted[p];
      assign sel_c4[p] = in_hot[6*p+4] & asserted[p];
      assign sel_c5[p] = in_hot[6*p+5] & asserted[p];
    end
  endgenerate

  // Active-low functions idle high when no pin drives them.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_up_request      <= 1'b0;
      power_down_request    <= 1'b0;
      regulator_enable_in   <= 1'b0;
      regulator_enable_in_n <= 1'b1;
      wake_request_n        <= 1'b1;
      low_power_request_1   <= 1'b0;
      low_power_request_2   <= 1'b0;
      low_power_request_3   <= 1'b0;
      flash_trigger         <= 1'b0;
      chip_reset_request    <= 1'b0;
      clk_32k_in            <= 1'b0;
    end else begin
      power_up_request      <= |sel_c1;
      power_down_request    <= sel_c4[0] | sel_c3[3];
      regulator_enable_in   <= sel_c2[3];
      regulator_enable_in_n <= ~(sel_c2[0] | sel_c2[1]);
      wake_request_n        <= ~(sel_c2[2] | sel_c4[1]);
      low_power_request_1   <= sel_c3[0];
      low_power_request_2   <= sel_c3[1];
      low_power_request_3   <= sel_c4[2];
      flash_trigger         <= sel_c4[3];
      chip_reset_request    <= sel_c5[0];
      clk_32k_in            <= sel_c3[2];
    end
  end
endmodule // gpfs_top

// ==== dv/gpfs_top_monitor.sv ====
// Port-level checker for the low-bank pin selector.
`timescale 1ns/1ps
`include "gpfs_regs.vh"
module gpfs_top_monitor (
  input wire        core_clk,         // Clock.
  input wire        rst_n,            // Reset, active low.
  input wire        sm_reset,         // Sequencer reset.
  input wire [7:0]  addr,             // Address.
  input wire [15:0] wr_data,          // Write data.
  input wire        wr_en,            // Write strobe.
  input wire        rd_en,            // Read strobe.
  input wire [15:0] rd_data_r,        // Read data.
  input wire [3:0]  gpio_dir_out,     // Directions.
  input wire [3:0]  gpio_out_data,    // GPIO output data.
  input wire [3:0]  gpio_in_data,     // GPIO input data.
  input wire [3:0]  pin_in,           // Pin levels.
  input wire [3:0]  pin_out,          // Pin outputs.
  input wire [3:0]  pin_oe_n,         // Pin enables.
  input wire        power_up_request, // Power-on request.
  input wire        clk_32k_src       // 32 kHz source.
);
  // ==========================================
  // Shadow copies of both registers, kept from bus traffic.
  reg [15:0] pol_r;
  reg [15:0] fsel_r;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n || sm_reset) begin
      pol_r  <= 16'h0000;
      fsel_r <= 16'h0013;
    end else if (wr_en && addr == `GPFS_ADDR_POL) begin
      pol_r  <= wr_data & 16'h01ff;
    end else if (wr_en && addr == `GPFS_ADDR_FSEL) begin
      fsel_r <= wr_data;
    end
  end
  // ==========================================
  // Assertions.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_restore_rd(a);
    sm_reset ##1 (rd_en && addr == a);
  endsequence
  chk_rd_pulse: assert property (rd_data_r != 16'h0000 |-> $past(rd_en))
    else $error("read data without strobe");
  chk_fsel_restore: assert property (s_restore_rd(`GPFS_ADDR_FSEL) |=> rd_data_r == 16'h0013)
    else $error("select not restored");
  chk_pol_restore: assert property (s_restore_rd(`GPFS_ADDR_POL) |=> rd_data_r == 16'h0000)
    else $error("polarity not restored");
  chk_pol_rsvd: assert property (rd_en && addr == `GPFS_ADDR_POL |=> rd_data_r[15:9] == 7'h00)
    else $error("polarity high bits set");
  chk_pin0_push: assert property ($past(rst_n && gpio_dir_out[0] && !pol_r[0] && fsel_r[3:0] == 4'h0)
    |-> !pin_oe_n[0] && pin_out[0] == $past(gpio_out_data[0])) else $error("push-pull drive wrong");
  chk_pin0_od: assert property ($past(rst_n && gpio_dir_out[0] && pol_r[0] && fsel_r[3:0] == 4'h0)
    |-> !pin_out[0] && pin_oe_n[0] == $past(gpio_out_data[0])) else $error("open-drain drive wrong");
  chk_pin0_inpol: assert property ($past(rst_n) |-> gpio_in_data[0] == ($past(pol_r[0]) ~^ $past(pin_in[0])))
    else $error("input polarity wrong");
  chk_pin3_clk: assert property ($past(rst_n && gpio_dir_out[3] && !pol_r[3] && fsel_r[15:12] == 4'h3)
    |-> pin_out[3] == $past(clk_32k_src)) else $error("clock route wrong");
  chk_pwr_up: assert property ($past(fsel_r == 16'h0001 && !gpio_dir_out[0], 2)
    && $past(fsel_r == 16'h0001 && !gpio_dir_out[0]) |-> power_up_request == $past(gpio_in_data[0]))
    else $error("power-on request wrong");
endmodule // gpfs_top_monitor
bind gpfs_top gpfs_top_monitor u_gpfs_top_monitor (.core_clk, .rst_n, .sm_reset, .addr, .wr_data, .wr_en,
  .rd_en, .rd_data_r, .gpio_dir_out, .gpio_out_data, .gpio_in_data, .pin_in, .pin_out, .pin_oe_n,
  .power_up_request, .clk_32k_src);

// ==== dv/gpfs_top_tb.sv ====
// Self-checking bench for the low-bank pin selector.
`timescale 1ns/1ps
module gpfs_top_tb;
  reg         core_clk;
  reg         rst_n;
  reg         sm_reset;
  reg         wr_en;
  reg         rd_en;
  reg  [7:0]  addr;
  reg  [15:0] wr_data;
  reg  [3:0]  dir;
  reg  [3:0]  pin;
  reg  [8:0]  s;
  wire [15:0] rd_data_r;
  wire [3:0]  pout;
  wire [3:0]  poe;
  wire [10:0] fo;
  reg  [23:0] otab [0:3];
  reg  [23:0] itab [0:3];
  integer     error_cnt;
  integer     num_checks;
  integer     p;
  integer     c;
  integer     v;
  // ==========================================
  // Design, with sources in s and input functions gathered in fo.
  gpfs_top u_gpfs_top (.core_clk(core_clk), .rst_n(rst_n), .sm_reset(sm_reset), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_r(rd_data_r), .gpio_dir_out(dir),
    .gpio_out_data({4{s[0]}}), .gpio_in_data(), .pin_in(pin), .pin_out(pout), .pin_oe_n(poe),
    .power_up_request(fo[0]), .power_down_request(fo[1]), .regulator_enable_in(fo[2]),
    .regulator_enable_in_n(fo[3]), .wake_request_n(fo[4]), .low_power_request_1(fo[5]),
    .low_power_request_2(fo[6]), .low_power_request_3(fo[7]), .flash_trigger(fo[8]),
    .chip_reset_request(fo[9]), .clk_32k_in(fo[10]), .clk_1m_src(s[1]), .clk_32k_src(s[2]),
    .backup_rail_monitor(s[3]), .memory_reset_n(s[4]), .sys_reset_n(s[5]), .por_n(s[6]),
    .power_up_state(s[7]), .data_output_config(s[8]));
  // ==========================================
  // Clock and watchdog.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #50000;
    error_cnt = error_cnt + 1;
    wrap_up;
  end
  // ==========================================
  // Tasks.
  task tick(input integer n);
    begin
      repeat (n) @(posedge core_clk);
      #1;
    end
  endtask
  // One bus cycle; read data is settled on return.
  task acc(input w, input [7:0] a, input [15:0] d);
    begin
      @(posedge core_clk);
      wr_en <= w;
      rd_en <= !w;
      addr <= a;
      wr_data <= d;
      tick(1);
      wr_en <= 1'b0;
      rd_en <= 1'b0;
    end
  endtask
  // Sequencer reset beside a lost write, then a read at once.
  task pulse_sm(input [7:0] a);
    begin
      @(posedge core_clk);
      sm_reset <= 1'b1;
      wr_en <= 1'b1;
      addr <= a;
      wr_data <= 16'hffff;
      @(posedge core_clk);
      sm_reset <= 1'b0;
      wr_en <= 1'b0;
      rd_en <= 1'b1;
      tick(1);
      rd_en <= 1'b0;
    end
  endtask
  task chk_reg(input [15:0] got, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task chk_pin(input [10:0] got, input [10:0] exp);
    chk_reg({5'h00, got}, {5'h00, exp});
  endtask
  task wrap_up;
    begin
      $display("errors %0d checks %0d", error_cnt, num_checks);
      if (error_cnt == 0 && num_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // ==========================================
  // Tests: source index per output code, function index per input code (f is none).
  initial begin
    error_cnt = 0;
    num_checks = 0;
    rst_n = 1'b0;
    {sm_reset, wr_en, rd_en, addr, wr_data, dir, pin, s} = 0;
    otab[0] = 24'h056370; otab[1] = 24'h024580; otab[2] = 24'h052370; otab[3] = 24'h042310;
    itab[0] = 24'h91530f; itab[1] = 24'hf4630f; itab[2] = 24'hf7a40f; itab[3] = 24'hf8120f;
    repeat (8) @(posedge core_clk);
    chk_pin(fo, 11'h018); chk_pin(poe, 4'hf);
    rst_n <= 1'b1;
    acc(0, 8'h87, 0); chk_reg(rd_data_r, 16'h0000);
    acc(0, 8'h8c, 0); chk_reg(rd_data_r, 16'h0013);
    acc(0, 8'h80, 0); chk_reg(rd_data_r, 16'h0000);
    acc(1, 8'h87, 16'hffff); acc(0, 8'h87, 0); chk_reg(rd_data_r, 16'h01ff);
    acc(1, 8'h8c, 16'h4321); acc(0, 8'h8c, 0); chk_reg(rd_data_r, 16'h4321);
    tick(1); chk_reg(rd_data_r, 16'h0000);
    pulse_sm(8'h8c); chk_reg(rd_data_r, 16'h0013);
    pulse_sm(8'h87); chk_reg(rd_data_r, 16'h0000);
    // Output tables, each code driven with the chosen source low and then high.
    dir <= 4'hf;
    for (p = 0; p < 4; p = p + 1)
      for (c = 0; c < 6; c = c + 1)
        for (v = 0; v < 2; v = v + 1) begin
          acc(1, 8'h8c, c[15:0] << (4 * p));
          s <= {9{~v[0]}} ^ (9'h001 << otab[p][4 * c +: 4]);
          tick(2);
          chk_pin(pout[p], v[0]);
          chk_pin(poe[p], 1'b0);
        end
    // Status shows all four pins as outputs with low, active-low inputs asserted.
    acc(0, 8'h8e, 0); chk_reg(rd_data_r, 16'h00ff);
    // Open-drain drive on pin 0: a high level releases the pin, a low level pulls it down.
    acc(1, 8'h87, 16'h0001); acc(1, 8'h8c, 0); s <= 9'h001; tick(2);
    chk_pin({pout[0], poe[0]}, 2'b01);
    s <= 9'h000; tick(2); chk_pin({pout[0], poe[0]}, 2'b00);
    // Input tables with active-high pins.
    dir <= 4'h0;
    acc(1, 8'h87, 16'h000f);
    for (p = 0; p < 4; p = p + 1)
      for (c = 0; c < 6; c = c + 1)
        for (v = 0; v < 2; v = v + 1) begin
          acc(1, 8'h8c, c[15:0] << (4 * p));
          pin <= {4{v[0]}};
          tick(3);
          chk_pin(fo, ((v[0] && itab[p][4 * c +: 4] != 4'hf) ? 11'h001 << itab[p][4 * c +: 4] : 11'h000) ^ 11'h018);
        end
    // Active-low input on pin 0 requests power-on while the pin is low.
    acc(1, 8'h87, 16'h0000); acc(1, 8'h8c, 16'h0001); pin <= 4'h0; tick(3);
    chk_pin(fo, 11'h019);
    // Status shows all pins as inputs, each asserted while held low.
    acc(0, 8'h8e, 0); chk_reg(rd_data_r, 16'h000f);
    wrap_up;
  end
endmodule // gpfs_top_tb
